// *** peripheral_interrupt_flags_enables_tb_top.sv ***
`timescale 1ns/1ns

// ------------------------------------------------------------
// bench for the interrupt flag and enable block
// ------------------------------------------------------------
module peripheral_interrupt_flags_enables_tb_top import pif_pkg::*; ;
	logic REF_CLK = 1'b0;
	logic RST_N = 1'b0;
	pif_event_type ev = '0;
	pif_bus_type bus;
	logic [7:0] rdd;
	logic irq;
	logic [15:0] vec;
	logic [7:0] d;
	int failures = 0;
	int compares = 0;
	// walked offsets; the last one is a hole in the map
	logic [15:0] ofs [11] = '{16'hFF22, 16'hFF23, 16'hFF24, 16'hFF25, 16'hFF26, 16'hFF27,
		16'hFF28, 16'hFF29, 16'hFF2C, 16'hFF2E, 16'hFF2D};
	logic [7:0] e_z [11] = '{default: 8'h00};
	// after all ones written: enables keep their implemented bits, flags and hole stay clear
	logic [7:0] e_w [11] = '{8'h7F, 8'h3F, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hFF, 8'h00, 8'h00};
	// after every event at once
	logic [7:0] e_f [11] = '{8'h7F, 8'h3F, 8'hFF, 8'hFF, 8'h7F, 8'h3F, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'h00};
	// after all zeros written: enables off, flags kept
	logic [7:0] e_k [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h3F, 8'hFF, 8'hFF,
		8'h00, 8'hFF, 8'h00};
	// single events: bit in the event word, flag place, source index
	int pos [7] = '{31, 9, 5, 28, 24, 18, 19};
	logic [15:0] fa [7] = '{16'hFF28, 16'hFF29, 16'hFF2E, 16'hFF26, 16'hFF26, 16'hFF27,
		16'hFF27};
	logic [7:0] fv [7] = '{8'h04, 8'h08, 8'h04, 8'h08, 8'h40, 8'h20, 8'h01};
	int vi [7] = '{18, 27, 34, 3, 6, 13, 8};

	// 10 MHz
	always #50 REF_CLK = ~REF_CLK;

	pif_irq_ctrl i_pif_irq_ctrl (
		.REF_CLK(REF_CLK),
		.RST_N(RST_N),
		.BUS(bus),
		.RD_DATA(rdd),
		.EVENTS(ev),
		.IRQ(irq),
		.IRQ_VEC(vec)
	);

	pif_cpu_model i_pif_cpu_model (
		.clk(REF_CLK),
		.bus(bus),
		.rd_data(rdd)
	);

	// ------------------------------------------------------------
	// compares and helpers
	// ------------------------------------------------------------
	task automatic conclude();
		if (failures == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	task automatic chkr(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t read %h exp %h", $time, g, e);
		end
	endtask : chkr

	task automatic chkv(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t vector %h exp %h", $time, g, e);
		end
	endtask : chkv

	task automatic chki(input logic g, input logic e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t irq %h exp %h", $time, g, e);
		end
	endtask : chki

	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		i_pif_cpu_model.rd(a, d);
		chkr(d, e);
	endtask : rdc

	task automatic sweep(input logic [7:0] e [11]);
		for (int i = 0; i < 11; i++) begin
			rdc(ofs[i], e[i]);
		end
	endtask : sweep

	task automatic wrall(input logic [7:0] v);
		for (int i = 0; i < 11; i++) begin
			i_pif_cpu_model.wr(ofs[i], v);
		end
	endtask : wrall

	// one-cycle event pulse; returns where the new flag has settled
	task automatic pulse(input pif_event_type v);
		@(posedge REF_CLK);
		ev <= v;
		@(posedge REF_CLK);
		ev <= '0;
		@(negedge REF_CLK);
	endtask : pulse

	task automatic reset();
		@(posedge REF_CLK);
		RST_N <= 1'b0;
		repeat (16) @(posedge REF_CLK);
		RST_N <= 1'b1;
	endtask : reset

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		reset();
		sweep(e_z);
		wrall(8'hFF);
		sweep(e_w);
		pulse('1);
		chki(irq, 1'b1);
		@(negedge REF_CLK);
		chkv(vec, PIF_VEC_BASE);
		sweep(e_f);
		wrall(8'h00);
		sweep(e_k);
		chki(irq, 1'b0);
		// clearing the lowest flag moves the vector one entry up
		i_pif_cpu_model.wr(16'hFF22, 8'h7F);
		i_pif_cpu_model.wr(16'hFF26, 8'h01);
		repeat (2) @(negedge REF_CLK);
		chkv(vec, PIF_VEC_BASE + 16'h0002);
		chki(irq, 1'b1);
		wrall(8'hFF);
		sweep(e_w);
		chki(irq, 1'b0);
		// seven sample sources each land on their own bit and vector
		for (int i = 0; i < 7; i++) begin
			pulse(pif_event_type'(37'h1 << pos[i]));
			chki(irq, 1'b1);
			@(negedge REF_CLK);
			chkv(vec, PIF_VEC_BASE + 16'(2 * vi[i]));
			rdc(fa[i], fv[i]);
			i_pif_cpu_model.wr(fa[i], fv[i]);
			rdc(fa[i], 8'h00);
		end
		// masked source holds its flag and asks again once enabled
		i_pif_cpu_model.wr(16'hFF24, 8'h00);
		pulse(pif_event_type'(37'h1 << 31));
		chki(irq, 1'b0);
		i_pif_cpu_model.wr(16'hFF24, 8'h04);
		@(negedge REF_CLK);
		chki(irq, 1'b1);
		i_pif_cpu_model.wr(16'hFF28, 8'h04);
		@(negedge REF_CLK);
		chki(irq, 1'b0);
		// event and clearing write in one cycle: the event wins
		fork
			i_pif_cpu_model.wr(16'hFF28, 8'h80);
			pulse(pif_event_type'(37'h1 << 36));
		join
		rdc(16'hFF28, 8'h80);
		// a second reset in mid-run, with flags and enables set, clears everything
		pulse('1);
		reset();
		chki(irq, 1'b0);
		sweep(e_z);
		conclude();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge REF_CLK);
		failures++;
		conclude();
	end
endmodule : peripheral_interrupt_flags_enables_tb_top

// *** pif_cpu_model.sv ***
`timescale 1ns/1ns

// ------------------------------------------------------------
// cpu core model on the register port
// ------------------------------------------------------------
module pif_cpu_model import pif_pkg::*; (
	input wire logic clk,
	output pif_bus_type bus,
	input wire logic [7:0] rd_data
);
	// bus idles at zero so no strobe leaks out of reset
	initial begin
		bus = '0;
	end

	// one-cycle write strobe; the slave never stalls
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask : wr

	// data stands only in the cycle after the strobe, taken at its closing edge
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
		d = rd_data;
	endtask : rd

	// only register traffic here, no sleep request ever issued
endmodule : pif_cpu_model

// *** pif_flag_reg.sv ***
`timescale 1ns/1ns

// sticky request flags, cleared by writing one
module pif_flag_reg import pif_pkg::*; #(
	parameter logic [7:0] MASK = PIF_FULL_MASK
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] set,
	input wire logic clr_we,
	input wire logic [7:0] clr_data,
	output logic [7:0] flags
);

	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [7:0] clr;

	// -----------------------------------------------------------
	// next value
	// -----------------------------------------------------------
	// a zero written leaves the flag alone; set beats clear
	assign clr = clr_we ? clr_data : 8'h00;
	assign flags_d = ((flags_q & ~clr) | set) & MASK;

	// unassigned bits never leave zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_q <= PIF_RESET_VAL;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign flags = flags_q;

endmodule : pif_flag_reg

// *** pif_irq_ctrl.sv ***
// Contract
// (R1) enable bit per match and underflow event, timers 0-3; reset 0
// (R2) separate enable register for timers 4-7 match and underflow; reset 0
// (R3) eight read/write key interrupt enables, one per key; reset 0
// (R4) clock-timer 1/2/8/32 Hz sticky flags; write one clears; zero ignored
// (R5) stopwatch 1/10/100 Hz flags in upper bits of clock flag register
// (R6) serial error, receive, transmit flags, both interfaces, six low bits
// (R7) key flags, bit n for key n, write one clears, reset clears
// (R8) timers 0-3 flags: match odd bits, underflow even bits, write one clears
// (R9) timers 4-7 flags, same arrangement and clearing as timers 0-3
// (R10) unassigned flag bits read zero and ignore writes
// (R11) request raised while a flag and its enable are both one
// (R12) request returns after exception return if flag still set
// (R13) lowering cpu level before clearing flag retakes same interrupt
// (R14) vectors are 2 bytes, no bank, handlers in common area
// (R15) software must not sleep within 2 ms after a non-maskable interrupt
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns

module pif_irq_ctrl import pif_pkg::*; #(
	parameter logic [15:0] VEC_BASE = PIF_VEC_BASE
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire pif_bus_type BUS,
	output logic [7:0] RD_DATA,
	input wire pif_event_type EVENTS,
	output logic IRQ,
	output logic [15:0] IRQ_VEC
);

	// all checks below run on the one clock and rest during reset, except en_reset_a, which stays active
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic wr_ct_en;
	logic wr_sif_en;
	logic wr_key_en;
	logic wr_ptl_en;
	logic wr_pth_en;
	logic wr_ct_flg;
	logic wr_sif_flg;
	logic wr_key_flg;
	logic wr_ptl_flg;
	logic wr_pth_flg;

	// write strobes, one per register
	assign wr_ct_en = BUS.wr && (BUS.addr == PIF_CT_EN_OFS);
	assign wr_sif_en = BUS.wr && (BUS.addr == PIF_SIF_EN_OFS);
	assign wr_key_en = BUS.wr && (BUS.addr == PIF_KEY_EN_OFS);
	assign wr_ptl_en = BUS.wr && (BUS.addr == PIF_PTL_EN_OFS);
	assign wr_pth_en = BUS.wr && (BUS.addr == PIF_PTH_EN_OFS);
	assign wr_ct_flg = BUS.wr && (BUS.addr == PIF_CT_FLG_OFS);
	assign wr_sif_flg = BUS.wr && (BUS.addr == PIF_SIF_FLG_OFS);
	assign wr_key_flg = BUS.wr && (BUS.addr == PIF_KEY_FLG_OFS);
	assign wr_ptl_flg = BUS.wr && (BUS.addr == PIF_PTL_FLG_OFS);
	assign wr_pth_flg = BUS.wr && (BUS.addr == PIF_PTH_FLG_OFS);

	// ------------------------------------------------------------
	// enable registers
	// ------------------------------------------------------------
	logic [7:0] ct_en_q;
	logic [7:0] sif_en_q;
	logic [7:0] key_en_q;
	logic [7:0] ptl_en_q;
	logic [7:0] pth_en_q;

	// plain read/write bits; spare positions are masked off
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			ct_en_q <= PIF_RESET_VAL;
			sif_en_q <= PIF_RESET_VAL;
			key_en_q <= PIF_RESET_VAL; // [R3]
			ptl_en_q <= PIF_RESET_VAL; // [R1]
			pth_en_q <= PIF_RESET_VAL; // [R2]
		end else begin
			if (wr_ct_en) ct_en_q <= BUS.wdata & PIF_CT_MASK;
			if (wr_sif_en) sif_en_q <= BUS.wdata & PIF_SIF_MASK;
			if (wr_key_en) key_en_q <= BUS.wdata; // [R3]
			if (wr_ptl_en) ptl_en_q <= BUS.wdata; // [R1]
			if (wr_pth_en) pth_en_q <= BUS.wdata; // [R2]
		end
	end

	// ------------------------------------------------------------
	// event to bit mapping
	// ------------------------------------------------------------
	// underflow on even bit, compare match on the odd bit above it
	function automatic logic [7:0] pair_bits(input logic [3:0] m, input logic [3:0] u);
		logic [7:0] r;
		r = 8'h00;
		for (int k = 0; k < 4; k++) begin
			r[2 * k] = u[k];
			r[2 * k + 1] = m[k];
		end
		return r;
	endfunction : pair_bits

	logic [7:0] ct_set;
	logic [7:0] sif_set;
	logic [7:0] ptl_set;
	logic [7:0] pth_set;

	// stopwatch above clock timer; interface 1 above interface 0
	assign ct_set = {1'b0, EVENTS.swatch, EVENTS.ctimer}; // [R4] [R5]
	assign sif_set = {2'b00, EVENTS.sif1, EVENTS.sif0}; // [R6]
	assign ptl_set = pair_bits(EVENTS.ptm_match[3:0], EVENTS.ptm_uflow[3:0]); // [R8]
	assign pth_set = pair_bits(EVENTS.ptm_match[7:4], EVENTS.ptm_uflow[7:4]); // [R9]

	// ------------------------------------------------------------
	// sticky flag registers
	// ------------------------------------------------------------
	logic [7:0] ct_flg;
	logic [7:0] sif_flg;
	logic [7:0] key_flg;
	logic [7:0] ptl_flg;
	logic [7:0] pth_flg;

	// clock timer and stopwatch, bit 7 unused
	pif_flag_reg #(.MASK(PIF_CT_MASK)) u_ct_flg (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.set(ct_set),
		.clr_we(wr_ct_flg), // [R4] [R5] [R10]
		.clr_data(BUS.wdata),
		.flags(ct_flg)
	);

	// two serial interfaces, bits 7:6 unused
	pif_flag_reg #(.MASK(PIF_SIF_MASK)) u_sif_flg (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.set(sif_set),
		.clr_we(wr_sif_flg), // [R6] [R10]
		.clr_data(BUS.wdata),
		.flags(sif_flg)
	);

	// key inputs, bit n for key n
	pif_flag_reg #(.MASK(PIF_FULL_MASK)) u_key_flg (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.set(EVENTS.key),
		.clr_we(wr_key_flg), // [R7]
		.clr_data(BUS.wdata),
		.flags(key_flg)
	);

	// programmable timers 0 to 3
	pif_flag_reg #(.MASK(PIF_FULL_MASK)) u_ptl_flg (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.set(ptl_set),
		.clr_we(wr_ptl_flg), // [R8]
		.clr_data(BUS.wdata),
		.flags(ptl_flg)
	);

	// programmable timers 4 to 7
	pif_flag_reg #(.MASK(PIF_FULL_MASK)) u_pth_flg (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.set(pth_set),
		.clr_we(wr_pth_flg), // [R9]
		.clr_data(BUS.wdata),
		.flags(pth_flg)
	);

	// ------------------------------------------------------------
	// request and vector
	// ------------------------------------------------------------
	logic [PIF_NUM_SRC-1:0] pending;
	logic [5:0] src_idx;
	logic [15:0] vec_d;
	logic [15:0] vec_q;

	// a request is a level: it stays while the flag stays, so an
	// early return or a lowered cpu level simply takes it again
	assign pending = {pth_flg & pth_en_q, ptl_flg & ptl_en_q, key_flg & key_en_q,
		sif_flg & sif_en_q, ct_flg & ct_en_q}; // [R11]
	assign IRQ = |pending; // [R11] [R12] [R13]

	// lowest pending source wins; the real level scheme sits in the cpu
	function automatic logic [5:0] first_src(input logic [PIF_NUM_SRC-1:0] p);
		logic [5:0] r;
		r = 6'h00;
		for (int i = PIF_NUM_SRC - 1; i >= 0; i--) begin
			if (p[i]) r = 6'(i);
		end
		return r;
	endfunction : first_src

	assign src_idx = first_src(pending);
	// two bytes per entry, no bank part in the address
	assign vec_d = VEC_BASE + {9'h000, src_idx, 1'b0}; // [R14]

	// vector lags the request by one cycle
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			vec_q <= VEC_BASE;
		end else begin
			vec_q <= vec_d;
		end
	end

	assign IRQ_VEC = vec_q;

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [7:0] rd_mux;
	logic [7:0] rdata_q;

	// unmapped addresses read zero
	assign rd_mux = (BUS.addr == PIF_CT_EN_OFS) ? ct_en_q :
		(BUS.addr == PIF_SIF_EN_OFS) ? sif_en_q :
		(BUS.addr == PIF_KEY_EN_OFS) ? key_en_q :
		(BUS.addr == PIF_PTL_EN_OFS) ? ptl_en_q :
		(BUS.addr == PIF_PTH_EN_OFS) ? pth_en_q :
		(BUS.addr == PIF_CT_FLG_OFS) ? ct_flg :
		(BUS.addr == PIF_SIF_FLG_OFS) ? sif_flg :
		(BUS.addr == PIF_KEY_FLG_OFS) ? key_flg :
		(BUS.addr == PIF_PTL_FLG_OFS) ? ptl_flg :
		(BUS.addr == PIF_PTH_FLG_OFS) ? pth_flg : 8'h00;

	// data stands only in the cycle after the read strobe
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			rdata_q <= PIF_RESET_VAL;
		end else begin
			rdata_q <= BUS.rd ? rd_mux : 8'h00;
		end
	end

	assign RD_DATA = rdata_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	en_reset_a: assert property (@(posedge REF_CLK) disable iff (1'b0) // [R1] [R2] [R3]
		!RST_N |=> (ptl_en_q == 8'h00) && (pth_en_q == 8'h00) && (key_en_q == 8'h00))
		else $error("enable not cleared by reset");

	low_en_write_a: assert property (wr_ptl_en |=> ptl_en_q == $past(BUS.wdata)) // [R1]
		else $error("timer 0-3 enable write lost");

	high_en_write_a: assert property (wr_pth_en |=> pth_en_q == $past(BUS.wdata)) // [R2]
		else $error("timer 4-7 enable write lost");

	key_en_keep_a: assert property (!wr_key_en |=> $stable(key_en_q)) // [R3]
		else $error("key enable changed without write");

	clock_set_a: assert property (EVENTS.ctimer[3] |=> ct_flg[3] ##1 ct_flg[3] || $past(wr_ct_flg)) // [R4]
		else $error("32 Hz flag not set or not sticky");

	clock_clear_a: assert property (wr_ct_flg && BUS.wdata[0] && !EVENTS.ctimer[0] |=> !ct_flg[0]) // [R4]
		else $error("clock flag not cleared by one");

	watch_set_a: assert property (EVENTS.swatch[2] |=> ct_flg[6]) // [R5]
		else $error("100 Hz flag not set");

	serial_set_a: assert property (EVENTS.sif1[2] |=> sif_flg[5]) // [R6]
		else $error("serial 1 error flag not set");

	key_set_a: assert property (EVENTS.key[7] && wr_key_flg |=> key_flg[7]) // [R7]
		else $error("key event lost to clear");

	zero_write_a: assert property (ptl_flg[0] && wr_ptl_flg && !BUS.wdata[0] |=> ptl_flg[0]) // [R8]
		else $error("zero write cleared a flag");

	match_odd_a: assert property (EVENTS.ptm_match[7] |=> pth_flg[7] && // [R9]
		$past(pth_set[6]) == $past(EVENTS.ptm_uflow[7]))
		else $error("timer 7 match not on bit 7");

	spare_zero_a: assert property (ct_flg[7] == 1'b0 && sif_flg[7:6] == 2'b00) // [R10]
		else $error("unassigned flag bit set");

	irq_hold_a: assert property (IRQ && !BUS.wr |=> IRQ) // [R11] [R12] [R13]
		else $error("request dropped while flag held");

	vec_area_a: assert property (IRQ ##1 IRQ |-> IRQ_VEC <= PIF_COMMON_TOP && !IRQ_VEC[0]) // [R14]
		else $error("vector outside common area");

	read_data_a: assert property (BUS.rd && BUS.addr == PIF_KEY_FLG_OFS |=> // [R7]
		RD_DATA == $past(key_flg))
		else $error("key flag read wrong");

	key_irq_c: cover property (EVENTS.key[0] && key_en_q[0] ##1 IRQ);
	clear_irq_c: cover property (IRQ && wr_key_flg ##1 !IRQ);
	read_back_c: cover property (BUS.rd ##1 RD_DATA != 8'h00);

endmodule : pif_irq_ctrl

// *** pif_pkg.sv ***
package pif_pkg;

	// ------------------------------------------------------------
	// register offsets on the internal data bus
	// ------------------------------------------------------------
	localparam logic [15:0] PIF_CT_EN_OFS = 16'hFF22;
	localparam logic [15:0] PIF_SIF_EN_OFS = 16'hFF23;
	localparam logic [15:0] PIF_KEY_EN_OFS = 16'hFF24;
	localparam logic [15:0] PIF_PTL_EN_OFS = 16'hFF25;
	localparam logic [15:0] PIF_CT_FLG_OFS = 16'hFF26;
	localparam logic [15:0] PIF_SIF_FLG_OFS = 16'hFF27;
	localparam logic [15:0] PIF_KEY_FLG_OFS = 16'hFF28;
	localparam logic [15:0] PIF_PTL_FLG_OFS = 16'hFF29;
	localparam logic [15:0] PIF_PTH_EN_OFS = 16'hFF2C;
	localparam logic [15:0] PIF_PTH_FLG_OFS = 16'hFF2E;

	// ------------------------------------------------------------
	// implemented bits and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] PIF_CT_MASK = 8'h7F;
	localparam logic [7:0] PIF_SIF_MASK = 8'h3F;
	localparam logic [7:0] PIF_FULL_MASK = 8'hFF;
	localparam logic [7:0] PIF_RESET_VAL = 8'h00;

	// ------------------------------------------------------------
	// vector table: 2-byte entries inside the common area
	// ------------------------------------------------------------
	localparam logic [15:0] PIF_VEC_BASE = 16'h0010;
	localparam logic [15:0] PIF_COMMON_TOP = 16'h7FFF;
	localparam int PIF_NUM_SRC = 40;

	// one-cycle event pulses from the peripherals
	typedef struct packed {
		logic [7:0] key;
		logic [3:0] ctimer;
		logic [2:0] swatch;
		logic [2:0] sif0;
		logic [2:0] sif1;
		logic [7:0] ptm_match;
		logic [7:0] ptm_uflow;
	} pif_event_type;

	// register port from the cpu core
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pif_bus_type;

endpackage : pif_pkg
